// ### core/in2_cfg_pkg.sv
/*
  Constants for the second input channel configuration bank: register
  addresses, reset values, field positions, write masks and code points.
  Assumes: byte-wide registers on an 8-bit address register port.
*/
package in2_cfg_pkg;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [7:0] ADDR_INPUT_SETUP = 8'h41;
  localparam logic [7:0] ADDR_GAIN_SETTING = 8'h42;
  localparam logic [7:0] ADDR_DIGITAL_VOLUME = 8'h43;
  localparam logic [7:0] ADDR_GAIN_TRIM = 8'h44;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_INPUT_SETUP = 8'h10;
  localparam logic [7:0] RST_GAIN_SETTING = 8'h00;
  localparam logic [7:0] RST_DIGITAL_VOLUME = 8'hC9;
  localparam logic [7:0] RST_GAIN_TRIM = 8'h80;

  // ************************************************************
  // write masks: a 0 bit is read-only and reads as zero
  // ************************************************************
  localparam logic [7:0] WMASK_INPUT_SETUP = 8'hFF;
  localparam logic [7:0] WMASK_GAIN_SETTING = 8'hFE;
  localparam logic [7:0] WMASK_DIGITAL_VOLUME = 8'hFF;
  localparam logic [7:0] WMASK_GAIN_TRIM = 8'hF0;

  // ************************************************************
  // field positions in the input setup register
  // ************************************************************
  localparam int SOURCE_KIND_BIT = 7;
  localparam int ENDED_SEL_HI = 6;
  localparam int ENDED_SEL_LO = 5;
  localparam int COUPLING_BIT = 4;
  localparam int SWING_RANGE_BIT = 3;
  localparam int REJECTION_HI = 2;
  localparam int REJECTION_LO = 1;
  localparam int AUTO_GAIN_BIT = 0;

  // field positions in the gain and trim registers
  localparam int GAIN_CODE_HI = 7;
  localparam int GAIN_CODE_LO = 2;
  localparam int GAIN_SPARE_BIT = 1;
  localparam int TRIM_CODE_HI = 7;
  localparam int TRIM_CODE_LO = 4;

  // ************************************************************
  // code points
  // ************************************************************
  localparam logic [1:0] ENDED_DIFFERENTIAL = 2'h0;
  localparam logic [1:0] ENDED_SINGLE = 2'h1;
  localparam logic [1:0] REJECT_HIGH_SNR = 2'h0;
  localparam logic [1:0] REJECT_FORBIDDEN = 2'h1;
  localparam logic [1:0] REJECT_HIGH_CMRR = 2'h2;
  localparam logic [5:0] GAIN_MAX_CODE = 6'h2A;
  localparam logic [7:0] VOLUME_MUTE_CODE = 8'h00;
  localparam logic [7:0] VOLUME_UNITY_CODE = 8'hC9;
  localparam logic [3:0] TRIM_ZERO_CODE = 4'h8;

endpackage

// ### core/in2_code_decode.sv
/*
  Turns the stored gain, volume and trim codes into step counts, signed for
  volume and trim, and flags, one register stage deep.
  Assumes: codes come from flip-flops of the register bank.
*/
`timescale 1ns/10ps
module in2_code_decode
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // stored codes
  input wire logic [5:0] gain_code_i,
  input wire logic [7:0] volume_code_i,
  input wire logic [3:0] trim_code_i,
  // decoded values
  output logic [5:0] gain_db_o,
  output logic gain_reserved_o,
  output logic signed [8:0] volume_half_db_o,
  output logic volume_mute_o,
  output logic signed [4:0] trim_tenth_db_o
);

  typedef struct packed {
    logic [5:0] gain_db;
    logic gain_reserved;
    logic signed [8:0] volume_half_db;
    logic volume_mute;
    logic signed [4:0] trim_tenth_db;
  } dec_state_t;

  dec_state_t state_r;
  dec_state_t state_nxt;

  // next decoded values from the codes
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.gain_db = gain_code_i;
    state_nxt.gain_reserved = (gain_code_i > in2_cfg_pkg::GAIN_MAX_CODE);
    state_nxt.volume_mute = (volume_code_i == in2_cfg_pkg::VOLUME_MUTE_CODE);
    state_nxt.volume_half_db = 9'(signed'({1'b0, volume_code_i})
      - signed'({1'b0, in2_cfg_pkg::VOLUME_UNITY_CODE}));
    state_nxt.trim_tenth_db = 5'(signed'({1'b0, trim_code_i})
      - signed'({1'b0, in2_cfg_pkg::TRIM_ZERO_CODE}));
  end

  // reset shows unity volume, no gain, no trim
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign gain_db_o = state_r.gain_db;
  assign gain_reserved_o = state_r.gain_reserved;
  assign volume_half_db_o = state_r.volume_half_db;
  assign volume_mute_o = state_r.volume_mute;
  assign trim_tenth_db_o = state_r.trim_tenth_db;

endmodule // in2_code_decode

// ### core/in2_config_bank.sv
/*
  Configuration register bank of the second input channel: input setup,
  channel gain, digital volume and gain trim, with decoded controls.
  Assumes: a simple synchronous register port from the control interface
  front end; one access per cycle; read data answer one cycle later.
*/
`timescale 1ns/10ps
module in2_config_bank
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_en_i,
  input wire logic [7:0] reg_wr_data_i,
  input wire logic reg_rd_en_i,
  output logic [7:0] reg_rd_data_o,
  output logic reg_rd_valid_o,
  // auto gain mode bit from the auto gain mode register
  input wire logic auto_gain_mode_i,
  // input setup controls
  output logic in2_source_kind_o,
  output logic [1:0] in2_ended_select_o,
  output logic in2_ended_reserved_o,
  output logic in2_coupling_select_o,
  output logic in2_swing_range_o,
  output logic [1:0] in2_rejection_mode_o,
  output logic in2_rejection_bad_o,
  output logic in2_auto_gain_enable_o,
  output logic in2_auto_gain_mode_o,
  output logic in2_auto_gain_conflict_o,
  // stored codes
  output logic [5:0] in2_gain_code_o,
  output logic [7:0] in2_volume_code_o,
  output logic [3:0] in2_gain_trim_code_o,
  // decoded values
  output logic [5:0] gain_db_o,
  output logic gain_reserved_o,
  output logic signed [8:0] volume_half_db_o,
  output logic volume_mute_o,
  output logic signed [4:0] trim_tenth_db_o
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0] input_setup;
    logic [7:0] gain_setting;
    logic [7:0] digital_volume;
    logic [7:0] gain_trim;
    logic [7:0] rd_data;
    logic rd_valid;
    logic ag_mode;
  } bank_state_t;

  localparam bank_state_t BANK_RESET = '{
    input_setup: in2_cfg_pkg::RST_INPUT_SETUP,
    gain_setting: in2_cfg_pkg::RST_GAIN_SETTING,
    digital_volume: in2_cfg_pkg::RST_DIGITAL_VOLUME,
    gain_trim: in2_cfg_pkg::RST_GAIN_TRIM,
    rd_data: 8'h00,
    rd_valid: 1'b0,
    ag_mode: 1'b0
  };

  bank_state_t state_r;
  bank_state_t state_nxt;

  // ************************************************************
  // write, read and mode tracking
  // ************************************************************
  // masked writes keep read-only bits at zero whatever is written
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.rd_valid = reg_rd_en_i;
    // auto gain mode is only followed while auto gain is enabled
    state_nxt.ag_mode = state_r.input_setup[in2_cfg_pkg::AUTO_GAIN_BIT] & auto_gain_mode_i;
    if (reg_wr_en_i)
    begin
      // input setup at its fixed address
      if (reg_addr_i == in2_cfg_pkg::ADDR_INPUT_SETUP)
      begin
        state_nxt.input_setup = reg_wr_data_i & in2_cfg_pkg::WMASK_INPUT_SETUP;
      end
      // spare bit stored, bit 0 dropped
      else if (reg_addr_i == in2_cfg_pkg::ADDR_GAIN_SETTING)
      begin
        state_nxt.gain_setting = reg_wr_data_i & in2_cfg_pkg::WMASK_GAIN_SETTING;
      end
      else if (reg_addr_i == in2_cfg_pkg::ADDR_DIGITAL_VOLUME)
      begin
        state_nxt.digital_volume = reg_wr_data_i & in2_cfg_pkg::WMASK_DIGITAL_VOLUME;
      end
      else if (reg_addr_i == in2_cfg_pkg::ADDR_GAIN_TRIM)
      begin
        state_nxt.gain_trim = reg_wr_data_i & in2_cfg_pkg::WMASK_GAIN_TRIM;
      end
    end
    // read returns stored value, unmapped reads zero
    if (!reg_rd_en_i)
    begin
      state_nxt.rd_data = state_r.rd_data;
    end
    else if (reg_addr_i == in2_cfg_pkg::ADDR_INPUT_SETUP)
    begin
      state_nxt.rd_data = state_r.input_setup;
    end
    else if (reg_addr_i == in2_cfg_pkg::ADDR_GAIN_SETTING)
    begin
      state_nxt.rd_data = state_r.gain_setting;
    end
    else if (reg_addr_i == in2_cfg_pkg::ADDR_DIGITAL_VOLUME)
    begin
      state_nxt.rd_data = state_r.digital_volume;
    end
    else if (reg_addr_i == in2_cfg_pkg::ADDR_GAIN_TRIM)
    begin
      state_nxt.rd_data = state_r.gain_trim;
    end
    else
    begin
      state_nxt.rd_data = 8'h00;
    end
  end

  // reset loads unity volume and other documented values
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_r <= BANK_RESET;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign reg_rd_data_o = state_r.rd_data;
  assign reg_rd_valid_o = state_r.rd_valid;

  assign in2_source_kind_o = state_r.input_setup[in2_cfg_pkg::SOURCE_KIND_BIT];
  assign in2_ended_select_o =
    state_r.input_setup[in2_cfg_pkg::ENDED_SEL_HI:in2_cfg_pkg::ENDED_SEL_LO];
  assign in2_ended_reserved_o = state_r.input_setup[in2_cfg_pkg::ENDED_SEL_HI];
  assign in2_coupling_select_o = state_r.input_setup[in2_cfg_pkg::COUPLING_BIT];
  assign in2_swing_range_o = state_r.input_setup[in2_cfg_pkg::SWING_RANGE_BIT];
  // rejection mode, codes 1 and 3 flagged as unusable
  assign in2_rejection_mode_o =
    state_r.input_setup[in2_cfg_pkg::REJECTION_HI:in2_cfg_pkg::REJECTION_LO];
  assign in2_rejection_bad_o = state_r.input_setup[in2_cfg_pkg::REJECTION_LO];
  // auto gain enable, its mode, and a DC-coupling warning
  assign in2_auto_gain_enable_o = state_r.input_setup[in2_cfg_pkg::AUTO_GAIN_BIT];
  assign in2_auto_gain_mode_o = state_r.ag_mode;
  assign in2_auto_gain_conflict_o = in2_auto_gain_enable_o & in2_coupling_select_o;

  assign in2_gain_code_o = state_r.gain_setting[in2_cfg_pkg::GAIN_CODE_HI:in2_cfg_pkg::GAIN_CODE_LO];
  assign in2_volume_code_o = state_r.digital_volume;
  assign in2_gain_trim_code_o =
    state_r.gain_trim[in2_cfg_pkg::TRIM_CODE_HI:in2_cfg_pkg::TRIM_CODE_LO];

  // step decoding kept apart so the bank stays a plain register file
  in2_code_decode u_decode
  (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .gain_code_i(in2_gain_code_o),
    .volume_code_i(in2_volume_code_o),
    .trim_code_i(in2_gain_trim_code_o),
    .gain_db_o(gain_db_o),
    .gain_reserved_o(gain_reserved_o),
    .volume_half_db_o(volume_half_db_o),
    .volume_mute_o(volume_mute_o),
    .trim_tenth_db_o(trim_tenth_db_o)
  );

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence wr_setup_s;
    reg_wr_en_i && (reg_addr_i == in2_cfg_pkg::ADDR_INPUT_SETUP);
  endsequence

  sequence rd_setup_s;
    reg_rd_en_i && !reg_wr_en_i && (reg_addr_i == in2_cfg_pkg::ADDR_INPUT_SETUP);
  endsequence

  sequence rd_gain_s;
    reg_rd_en_i && (reg_addr_i == in2_cfg_pkg::ADDR_GAIN_SETTING);
  endsequence

  sequence rd_trim_s;
    reg_rd_en_i && (reg_addr_i == in2_cfg_pkg::ADDR_GAIN_TRIM);
  endsequence

  // setup write then read returns the written byte
  setup_readback_a: assert property (
    wr_setup_s ##1 !reg_wr_en_i ##1 rd_setup_s
      |=> reg_rd_valid_o && (reg_rd_data_o == $past(reg_wr_data_i, 3)))
    else $error("input setup read back differs from write");

  // setup fields follow the write
  setup_fields_a: assert property (
    wr_setup_s |=> (in2_source_kind_o == $past(reg_wr_data_i[7]))
      && (in2_ended_select_o == $past(reg_wr_data_i[6:5]))
      && (in2_coupling_select_o == $past(reg_wr_data_i[4])))
    else $error("input setup fields do not follow write");

  // gain bit 0 always reads zero
  gain_low_zero_a: assert property (
    rd_gain_s |=> reg_rd_valid_o && (reg_rd_data_o[0] == 1'b0))
    else $error("gain read-only bit not zero");

  // trim low nibble always reads zero
  trim_low_zero_a: assert property (
    rd_trim_s |=> reg_rd_valid_o && (reg_rd_data_o[3:0] == 4'h0))
    else $error("trim read-only bits not zero");

  // zero volume mutes two cycles after the write
  volume_mute_a: assert property (
    reg_wr_en_i && (reg_addr_i == in2_cfg_pkg::ADDR_DIGITAL_VOLUME)
      && (reg_wr_data_i == 8'h00) ##1 !reg_wr_en_i |=> volume_mute_o)
    else $error("zero volume code did not mute");

  // volume step value tracks the code
  volume_step_a: assert property (
    volume_half_db_o == 9'(signed'({1'b0, $past(in2_volume_code_o)}) - 10'sd201))
    else $error("volume step value wrong");

  // gain in range decodes to its own dB value
  gain_decode_a: assert property (
    !gain_reserved_o |-> (gain_db_o <= 6'd42) && (gain_db_o == $past(in2_gain_code_o)))
    else $error("gain decode wrong");

  // trim of code eight is zero dB
  trim_zero_a: assert property (
    ($past(in2_gain_trim_code_o) == 4'h8) |-> (trim_tenth_db_o == 5'sd0))
    else $error("trim zero code not zero dB");

  // external mode bit only reaches the channel while auto gain is enabled
  auto_gain_mode_a: assert property (
    in2_auto_gain_mode_o == $past(in2_auto_gain_enable_o && auto_gain_mode_i))
    else $error("auto gain mode does not follow enable and mode bit");

  // remaining setup fields follow the write
  setup_low_fields_a: assert property (
    wr_setup_s |=> (in2_swing_range_o == $past(reg_wr_data_i[3]))
      && (in2_rejection_mode_o == $past(reg_wr_data_i[2:1]))
      && (in2_auto_gain_enable_o == $past(reg_wr_data_i[0])))
    else $error("input setup low fields do not follow write");

  // gain code follows its write, spare bits aside
  gain_code_follow_a: assert property (
    reg_wr_en_i && (reg_addr_i == in2_cfg_pkg::ADDR_GAIN_SETTING)
      |=> in2_gain_code_o == $past(reg_wr_data_i[7:2]))
    else $error("gain code does not follow write");

  // volume code follows its write
  volume_code_follow_a: assert property (
    reg_wr_en_i && (reg_addr_i == in2_cfg_pkg::ADDR_DIGITAL_VOLUME)
      |=> in2_volume_code_o == $past(reg_wr_data_i))
    else $error("volume code does not follow write");

  // trim code follows its write, low nibble dropped
  trim_code_follow_a: assert property (
    reg_wr_en_i && (reg_addr_i == in2_cfg_pkg::ADDR_GAIN_TRIM)
      |=> in2_gain_trim_code_o == $past(reg_wr_data_i[7:4]))
    else $error("trim code does not follow write");

  // read valid answers each strobe for exactly one cycle
  rd_valid_pulse_a: assert property (
    reg_rd_valid_o == $past(reg_rd_en_i))
    else $error("read valid not one cycle after strobe");

  // unmapped read answers zero, below and above the bank
  unmapped_zero_a: assert property (
    reg_rd_en_i && ((reg_addr_i < in2_cfg_pkg::ADDR_INPUT_SETUP)
      || (reg_addr_i > in2_cfg_pkg::ADDR_GAIN_TRIM)) |=> reg_rd_data_o == 8'h00)
    else $error("unmapped read not zero");

endmodule // in2_config_bank

// ### tb/in2_config_bank_tb_top.sv
/*
  Self-checking bench for the second input channel configuration bank:
  register reads and writes over the bank's own port, field decode checks.
  Assumes: the bank and its decode stage are compiled with in2_cfg_pkg.
*/
`timescale 1ns/10ps
module in2_config_bank_tb_top;
  // ************************************************************
  // clock, reset and design signals
  // ************************************************************
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_en_i = 1'b0;
  logic [7:0] reg_wr_data_i = 8'h00;
  logic reg_rd_en_i = 1'b0;
  logic auto_gain_mode_i = 1'b0;
  logic [7:0] reg_rd_data_o;
  logic reg_rd_valid_o;
  logic in2_source_kind_o;
  logic [1:0] in2_ended_select_o;
  logic in2_ended_reserved_o;
  logic in2_coupling_select_o;
  logic in2_swing_range_o;
  logic [1:0] in2_rejection_mode_o;
  logic in2_rejection_bad_o;
  logic in2_auto_gain_enable_o;
  logic in2_auto_gain_mode_o;
  logic in2_auto_gain_conflict_o;
  logic [5:0] in2_gain_code_o;
  logic [7:0] in2_volume_code_o;
  logic [3:0] in2_gain_trim_code_o;
  logic [5:0] gain_db_o;
  logic gain_reserved_o;
  logic signed [8:0] volume_half_db_o;
  logic volume_mute_o;
  logic signed [4:0] trim_tenth_db_o;
  int mismatches = 0;
  int n_tests = 0;

  in2_config_bank i_in2_config_bank
  (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_en_i(reg_wr_en_i), .reg_wr_data_i(reg_wr_data_i), .reg_rd_en_i(reg_rd_en_i),
    .reg_rd_data_o(reg_rd_data_o), .reg_rd_valid_o(reg_rd_valid_o),
    .auto_gain_mode_i(auto_gain_mode_i), .in2_source_kind_o(in2_source_kind_o),
    .in2_ended_select_o(in2_ended_select_o), .in2_ended_reserved_o(in2_ended_reserved_o),
    .in2_coupling_select_o(in2_coupling_select_o), .in2_swing_range_o(in2_swing_range_o),
    .in2_rejection_mode_o(in2_rejection_mode_o), .in2_rejection_bad_o(in2_rejection_bad_o),
    .in2_auto_gain_enable_o(in2_auto_gain_enable_o),
    .in2_auto_gain_mode_o(in2_auto_gain_mode_o),
    .in2_auto_gain_conflict_o(in2_auto_gain_conflict_o),
    .in2_gain_code_o(in2_gain_code_o), .in2_volume_code_o(in2_volume_code_o),
    .in2_gain_trim_code_o(in2_gain_trim_code_o), .gain_db_o(gain_db_o),
    .gain_reserved_o(gain_reserved_o), .volume_half_db_o(volume_half_db_o),
    .volume_mute_o(volume_mute_o), .trim_tenth_db_o(trim_tenth_db_o)
  );

  // 4 ns period, 250 MHz
  initial
  begin
    forever #2 core_clk_i = ~core_clk_i;
  end

  // ************************************************************
  // access and compare tasks
  // ************************************************************
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one strobe cycle; taken at the following edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wr_data_i <= d;
    reg_wr_en_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_en_i <= 1'b0;
  endtask

  // answer is registered at the taking edge itself, so sample just after it
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_en_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_en_i <= 1'b0;
    #1;
    check("rd_valid", {8'h00, reg_rd_valid_o}, 9'h001);
    check("rd_data", {1'b0, reg_rd_data_o}, {1'b0, e});
  endtask

  // decoded outputs lag the stored codes by one more cycle
  task automatic settle();
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask

  // reset held six cycles, then every register reads its reset value
  task automatic reset_and_check();
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    rd(in2_cfg_pkg::ADDR_INPUT_SETUP, 8'h10);
    rd(in2_cfg_pkg::ADDR_GAIN_SETTING, 8'h00);
    rd(in2_cfg_pkg::ADDR_DIGITAL_VOLUME, 8'hC9);
    rd(in2_cfg_pkg::ADDR_GAIN_TRIM, 8'h80);
    check("source", {8'h00, in2_source_kind_o}, 9'h000);
    check("coupling", {8'h00, in2_coupling_select_o}, 9'h001);
    check("swing", {8'h00, in2_swing_range_o}, 9'h000);
    check("vol_db", volume_half_db_o, 9'h000);
    check("trim_db", {4'h0, trim_tenth_db_o}, 9'h000);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ************************************************************
  // test sequence
  // ************************************************************
  initial
  begin : main
    logic [7:0] setup_v[12];
    int vol_c[4];
    logic [7:0] v;
    int c;
    setup_v = '{8'h80, 8'h20, 8'h40, 8'h60, 8'h08, 8'h02,
                8'h04, 8'h06, 8'h21, 8'h11, 8'h31, 8'h01};
    vol_c = '{0, 1, 201, 255};
    reset_and_check();
    // every setup field and flag, read back and seen at the pins
    foreach (setup_v[i])
    begin
      v = setup_v[i];
      @(posedge core_clk_i);
      auto_gain_mode_i <= v[5];
      wr(in2_cfg_pkg::ADDR_INPUT_SETUP, v);
      // read straight after the write; the registered mode has settled by then
      rd(in2_cfg_pkg::ADDR_INPUT_SETUP, v);
      check("source", {8'h00, in2_source_kind_o}, {8'h00, v[7]});
      check("ended", {7'h00, in2_ended_select_o}, {7'h00, v[6:5]});
      check("ended_rsv", {8'h00, in2_ended_reserved_o}, {8'h00, v[6]});
      check("coupling", {8'h00, in2_coupling_select_o}, {8'h00, v[4]});
      check("swing", {8'h00, in2_swing_range_o}, {8'h00, v[3]});
      check("reject", {7'h00, in2_rejection_mode_o}, {7'h00, v[2:1]});
      check("reject_bad", {8'h00, in2_rejection_bad_o}, {8'h00, v[1]});
      check("agc_en", {8'h00, in2_auto_gain_enable_o}, {8'h00, v[0]});
      check("agc_mode", {8'h00, in2_auto_gain_mode_o}, {8'h00, v[0] & v[5]});
      check("agc_dc", {8'h00, in2_auto_gain_conflict_o}, {8'h00, v[0] & v[4]});
      if (v[3])
      begin
        // high swing: software re-tunes gain and volume for the larger level
        wr(in2_cfg_pkg::ADDR_GAIN_SETTING, 8'h28);
        wr(in2_cfg_pkg::ADDR_DIGITAL_VOLUME, 8'hB5);
        rd(in2_cfg_pkg::ADDR_GAIN_SETTING, 8'h28);
      end
    end
    // gain: top legal code, first reserved code, reserved bits
    wr(in2_cfg_pkg::ADDR_GAIN_SETTING, 8'hA8);
    settle();
    check("gain_db", {3'h0, gain_db_o}, 9'h02A);
    check("gain_rsv", {8'h00, gain_reserved_o}, 9'h000);
    wr(in2_cfg_pkg::ADDR_GAIN_SETTING, 8'hAF);
    settle();
    check("gain_code", {3'h0, in2_gain_code_o}, 9'h02B);
    check("gain_rsv", {8'h00, gain_reserved_o}, 9'h001);
    rd(in2_cfg_pkg::ADDR_GAIN_SETTING, 8'hAE);
    // volume: mute and the named steps
    foreach (vol_c[i])
    begin
      c = vol_c[i];
      wr(in2_cfg_pkg::ADDR_DIGITAL_VOLUME, 8'(c));
      settle();
      check("mute", {8'h00, volume_mute_o}, {8'h00, c == 0});
      check("vol_code", {1'b0, in2_volume_code_o}, {1'b0, 8'(c)});
      if (c != 0)
        check("vol_db", volume_half_db_o, 9'(c - 201));
      rd(in2_cfg_pkg::ADDR_DIGITAL_VOLUME, 8'(c));
    end
    // trim: both ends of the range, low nibble stays zero
    wr(in2_cfg_pkg::ADDR_GAIN_TRIM, 8'hFF);
    settle();
    check("trim_db", {4'h0, trim_tenth_db_o}, {4'h0, 5'(15 - 8)});
    check("trim_code", {5'h00, in2_gain_trim_code_o}, 9'h00F);
    rd(in2_cfg_pkg::ADDR_GAIN_TRIM, 8'hF0);
    wr(in2_cfg_pkg::ADDR_GAIN_TRIM, 8'h0A);
    settle();
    check("trim_db", {4'h0, trim_tenth_db_o}, {4'h0, 5'(0 - 8)});
    check("trim_code", {5'h00, in2_gain_trim_code_o}, 9'h000);
    rd(in2_cfg_pkg::ADDR_GAIN_TRIM, 8'h00);
    // unmapped places: writes lost, reads zero, input setup untouched
    wr(8'h40, 8'hFF);
    wr(8'h45, 8'hFF);
    rd(8'h45, 8'h00);
    rd(8'h40, 8'h00);
    rd(in2_cfg_pkg::ADDR_INPUT_SETUP, 8'h01);
    // write and read of one register in the same cycle sees the old value
    @(posedge core_clk_i);
    reg_addr_i <= in2_cfg_pkg::ADDR_DIGITAL_VOLUME;
    reg_wr_data_i <= 8'h10;
    reg_wr_en_i <= 1'b1;
    reg_rd_en_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_en_i <= 1'b0;
    reg_rd_en_i <= 1'b0;
    #1;
    check("rd_old", {1'b0, reg_rd_data_o}, 9'h0FF);
    rd(in2_cfg_pkg::ADDR_DIGITAL_VOLUME, 8'h10);
    // reset in mid-run brings every register back
    reset_and_check();
    summarize();
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    mismatches++;
    summarize();
  end
endmodule // in2_config_bank_tb_top
